// ---- core/emce_params.svh ----
// Contract
// - Write scratchpad: command, address low/high, data.
// - At scratchpad end, sixteen slots return CRC.
// - Copy needs exact three-byte authorization pattern.
// - Master keeps line released during program time.
// - Master verifies copy or repeats write-copy.
// - Reset pulse may end read memory anytime.
// - Idle line high; long lows reset devices.
// - Order: reset, network command, memory command, data; the device model and bench skip the network command.
// - Reset pulse from master, presence from device.
// - Open-drain drivers only on shared line.
`ifndef EMCE_PARAMS_SVH
`define EMCE_PARAMS_SVH
`define EMCE_CLK_NS 20
`define EMCE_CYC(ns) (((ns) + `EMCE_CLK_NS - 1) / `EMCE_CLK_NS)
`define EMCE_CYC_DN(ns) ((ns) / `EMCE_CLK_NS)
`define EMCE_T_RSTL_STD_NS 480000
`define EMCE_T_RSTH_STD_NS 480000
`define EMCE_T_MSP_STD_NS 70000
`define EMCE_T_SLOT_STD_NS 70000
`define EMCE_T_W0L_STD_NS 60000
`define EMCE_T_W1L_STD_NS 6000
`define EMCE_T_SMP_STD_NS 15000
`define EMCE_T_RSTL_OD_NS 70000
`define EMCE_T_RSTH_OD_NS 48000
`define EMCE_T_MSP_OD_NS 8500
`define EMCE_T_SLOT_OD_NS 10000
`define EMCE_T_W0L_OD_NS 7500
`define EMCE_T_W1L_OD_NS 1000
`define EMCE_T_SMP_OD_NS 2000
`define EMCE_T_IDLE_LOW_STD_NS 120000
`define EMCE_T_IDLE_LOW_OD_NS 16000
`define EMCE_T_PROG_WAIT_NS 5000000
`define EMCE_REG_CTRL 8'h00
`define EMCE_REG_TXD 8'h04
`define EMCE_REG_RXD 8'h08
`define EMCE_REG_STAT 8'h0C
`define EMCE_REG_CRC 8'h10
`define EMCE_CTRL_OP_LSB 0
`define EMCE_CTRL_OD_BIT 3
`define EMCE_STAT_BUSY_BIT 0
`define EMCE_STAT_PRES_BIT 1
`define EMCE_STAT_OD_BIT 2
`define EMCE_STAT_REFUSED_BIT 3
`define EMCE_STAT_FAULT_BIT 4
`define EMCE_STAT_CRCOK_BIT 5
`define EMCE_CRC_INIT 16'h0000
`define EMCE_CRC_POLY 16'hA001
`define EMCE_CRC_RESIDUE 16'hB001
`define EMCE_RESP_OKAY 2'h0
`define EMCE_RESP_SLVERR 2'h2
`endif

// ---- core/emce_pkg.sv ----
package emce_pkg;
  typedef enum logic [1:0] {EMCE_SLOT_RESET, EMCE_SLOT_W0, EMCE_SLOT_W1} emce_slot_e;
  typedef enum logic [2:0] {
    EMCE_OP_NONE, EMCE_OP_RESET, EMCE_OP_WRITE, EMCE_OP_READ, EMCE_OP_WAIT
  } emce_op_e;
  typedef struct packed {logic valid; emce_slot_e kind; logic od;} emce_wire_cmd_s;
  typedef struct packed {logic done; logic bit_val;} emce_wire_rsp_s;
  typedef struct packed {logic [15:0] low; logic [15:0] smp; logic [15:0] tot;} emce_tim_s;
  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } emce_axi_req_s;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } emce_axi_rsp_s;
endpackage

// ---- core/emce_wire.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "emce_params.svh"

module emce_wire #(
  parameter int unsigned RSTL_STD_CYC = `EMCE_CYC(`EMCE_T_RSTL_STD_NS),
  parameter int unsigned RSTH_STD_CYC = `EMCE_CYC(`EMCE_T_RSTH_STD_NS)
) (
  input wire logic clk_sys_in,
  input wire logic ce_in,
  input wire logic reset_in,
  input wire emce_pkg::emce_wire_cmd_s cmd_in,
  input wire logic line_in,
  output var emce_pkg::emce_wire_rsp_s rsp_out,
  output var logic line_oe_out
);
  import emce_pkg::*;

  typedef struct packed {
    logic busy;
    emce_slot_e kind;
    logic od;
    logic [15:0] cnt;
    logic sync1;
    logic sync2;
    logic oe;
    emce_wire_rsp_s rsp;
  } emce_wstate_s;

  emce_wstate_s q, d;
  emce_tim_s tim;

  function automatic emce_tim_s slot_tim(input emce_slot_e k, input logic od);
    emce_tim_s t;
    t = '0;
    unique case (k)
      EMCE_SLOT_RESET: begin
        t.low = od ? 16'(`EMCE_CYC(`EMCE_T_RSTL_OD_NS)) : 16'(RSTL_STD_CYC);
        t.smp = t.low + (od ? 16'(`EMCE_CYC(`EMCE_T_MSP_OD_NS)) : 16'(`EMCE_CYC(`EMCE_T_MSP_STD_NS)));
        t.tot = t.low + (od ? 16'(`EMCE_CYC(`EMCE_T_RSTH_OD_NS)) : 16'(RSTH_STD_CYC));
      end
      EMCE_SLOT_W0: t.low = od ? 16'(`EMCE_CYC(`EMCE_T_W0L_OD_NS)) : 16'(`EMCE_CYC(`EMCE_T_W0L_STD_NS));
      default: t.low = od ? 16'(`EMCE_CYC(`EMCE_T_W1L_OD_NS)) : 16'(`EMCE_CYC(`EMCE_T_W1L_STD_NS));
    endcase
    if (k != EMCE_SLOT_RESET) begin
      t.smp = od ? 16'(`EMCE_CYC(`EMCE_T_SMP_OD_NS)) : 16'(`EMCE_CYC(`EMCE_T_SMP_STD_NS));
      t.tot = od ? 16'(`EMCE_CYC(`EMCE_T_SLOT_OD_NS)) : 16'(`EMCE_CYC(`EMCE_T_SLOT_STD_NS));
    end
    return t;
  endfunction

  // The sampled level lags the pin by the two synchroniser stages; the sample points leave margin.
  always_comb begin
    tim = slot_tim(q.kind, q.od);
    d = q;
    d.sync1 = line_in;
    d.sync2 = q.sync1;
    d.rsp.done = 1'b0;
    if (q.busy) begin
      d.cnt = q.cnt + 16'h0001;
      d.oe = d.cnt < tim.low;
      if (q.cnt == tim.smp) begin
        d.rsp.bit_val = q.sync2;
      end
      if (q.cnt == tim.tot - 16'h0001) begin
        d.busy = 1'b0;
        d.oe = 1'b0;
        d.rsp.done = 1'b1;
      end
    end else if (cmd_in.valid) begin
      d.busy = 1'b1;
      d.kind = cmd_in.kind;
      d.od = cmd_in.od;
      d.cnt = 16'h0000;
      d.oe = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign rsp_out = q.rsp;
  assign line_oe_out = q.oe;
endmodule // emce_wire
`default_nettype wire

// ---- core/emce_host.sv ----
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "emce_params.svh"

module emce_host #(
  parameter int unsigned RSTL_STD_CYC = `EMCE_CYC(`EMCE_T_RSTL_STD_NS),
  parameter int unsigned RSTH_STD_CYC = `EMCE_CYC(`EMCE_T_RSTH_STD_NS),
  parameter int unsigned IDLE_LOW_STD_CYC = `EMCE_CYC_DN(`EMCE_T_IDLE_LOW_STD_NS),
  parameter int unsigned PROG_WAIT_CYC = `EMCE_CYC(`EMCE_T_PROG_WAIT_NS)
) (
  input wire logic clk_sys_in,
  input wire logic ce_in,
  input wire logic reset_in,
  input wire emce_pkg::emce_axi_req_s axi_req_in,
  output var emce_pkg::emce_axi_rsp_s axi_rsp_out,
  input wire logic line_in,
  output var logic line_low_out,
  output var logic line_oe_out
);
  import emce_pkg::*;

  localparam int unsigned RSTL_OD_CYC = `EMCE_CYC(`EMCE_T_RSTL_OD_NS);
  localparam int unsigned IDLE_LOW_OD_CYC = `EMCE_CYC_DN(`EMCE_T_IDLE_LOW_OD_NS);

  typedef enum logic [1:0] {EMCE_H_IDLE, EMCE_H_RESET, EMCE_H_BITS, EMCE_H_WAIT} emce_hst_e;

  typedef struct packed {
    emce_axi_rsp_s axi;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    emce_hst_e st;
    logic rd;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [15:0] crc;
    logic [19:0] wcnt;
    logic od;
    logic pres;
    logic refused;
    logic fault;
    emce_wire_cmd_s wcmd;
    logic low_lvl;
  } emce_hstate_s;

  emce_hstate_s q, d;
  emce_wire_rsp_s wrsp;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? `EMCE_CRC_POLY : 16'h0000);
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return a == `EMCE_REG_CTRL || a == `EMCE_REG_TXD || a == `EMCE_REG_RXD ||
           a == `EMCE_REG_STAT || a == `EMCE_REG_CRC;
  endfunction

  // A read slot is a write-one slot whose level is kept; both start the same way.
  function automatic emce_slot_e slot_of(input logic rd, input logic b);
    return (rd || b) ? EMCE_SLOT_W1 : EMCE_SLOT_W0;
  endfunction

  emce_wire #(
    .RSTL_STD_CYC(RSTL_STD_CYC),
    .RSTH_STD_CYC(RSTH_STD_CYC)
  ) u_wire (
    .clk_sys_in(clk_sys_in),
    .ce_in(ce_in),
    .reset_in(reset_in),
    .cmd_in(q.wcmd),
    .line_in(line_in),
    .rsp_out(wrsp),
    .line_oe_out(line_oe_out)
  );

  always_comb begin
    emce_op_e op;
    logic smp;
    op = EMCE_OP_NONE;
    smp = 1'b0;
    d = q;
    d.wcmd.valid = 1'b0;

    // Register writes; the response follows once both address and data are held.
    if (axi_req_in.awvalid && q.axi.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && q.axi.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req_in.wdata;
      d.wstrb = axi_req_in.wstrb;
    end
    if (q.axi.bvalid && axi_req_in.bready) begin
      d.axi.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.axi.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.axi.bvalid = 1'b1;
      d.axi.bresp = reg_hit(q.awaddr) ? `EMCE_RESP_OKAY : `EMCE_RESP_SLVERR;
      if (q.wstrb[0]) begin
        if (q.awaddr == `EMCE_REG_TXD) begin
          d.txd = q.wdata[7:0];
        end
        if (q.awaddr == `EMCE_REG_CRC) begin
          d.crc = `EMCE_CRC_INIT;
        end
        if (q.awaddr == `EMCE_REG_STAT) begin
          if (q.wdata[`EMCE_STAT_REFUSED_BIT]) begin
            d.refused = 1'b0;
          end
          if (q.wdata[`EMCE_STAT_FAULT_BIT]) begin
            d.fault = 1'b0;
          end
        end
        if (q.awaddr == `EMCE_REG_CTRL) begin
          d.od = q.wdata[`EMCE_CTRL_OD_BIT];
          op = emce_op_e'(q.wdata[`EMCE_CTRL_OP_LSB +: 3]);
        end
      end
    end

    // Commands are taken only between bytes, so a reset can cut a stream after any byte.
    if (op != EMCE_OP_NONE && q.st != EMCE_H_IDLE) begin
      d.refused = 1'b1;
    end else begin
      unique case (op)
        EMCE_OP_NONE: begin
        end
        EMCE_OP_RESET: begin
          d.st = EMCE_H_RESET;
          d.pres = 1'b0;
          d.wcmd.valid = 1'b1;
          d.wcmd.kind = EMCE_SLOT_RESET;
        end
        EMCE_OP_WRITE, EMCE_OP_READ: begin
          if (!q.pres) begin
            d.refused = 1'b1;
          end else begin
            d.st = EMCE_H_BITS;
            d.rd = op == EMCE_OP_READ;
            d.bitn = 3'h0;
            d.shreg = q.txd;
            d.wcmd.valid = 1'b1;
            d.wcmd.kind = slot_of(op == EMCE_OP_READ, q.txd[0]);
          end
        end
        EMCE_OP_WAIT: begin
          d.st = EMCE_H_WAIT;
          d.wcnt = 20'h00000;
        end
        default: d.refused = 1'b1;
      endcase
    end

    // Register reads have no side effects.
    if (q.axi.rvalid && axi_req_in.rready) begin
      d.axi.rvalid = 1'b0;
    end
    if (axi_req_in.arvalid && q.axi.arready) begin
      d.axi.rvalid = 1'b1;
      d.axi.rresp = reg_hit(axi_req_in.araddr) ? `EMCE_RESP_OKAY : `EMCE_RESP_SLVERR;
      d.axi.rdata = 32'h00000000;
      unique case (axi_req_in.araddr)
        `EMCE_REG_CTRL: d.axi.rdata[`EMCE_CTRL_OD_BIT] = q.od;
        `EMCE_REG_TXD: d.axi.rdata[7:0] = q.txd;
        `EMCE_REG_RXD: d.axi.rdata[7:0] = q.rxd;
        `EMCE_REG_STAT: begin
          d.axi.rdata[`EMCE_STAT_BUSY_BIT] = q.st != EMCE_H_IDLE;
          d.axi.rdata[`EMCE_STAT_PRES_BIT] = q.pres;
          d.axi.rdata[`EMCE_STAT_OD_BIT] = q.od;
          d.axi.rdata[`EMCE_STAT_REFUSED_BIT] = q.refused;
          d.axi.rdata[`EMCE_STAT_FAULT_BIT] = q.fault;
          d.axi.rdata[`EMCE_STAT_CRCOK_BIT] = q.crc == `EMCE_CRC_RESIDUE;
        end
        `EMCE_REG_CRC: d.axi.rdata[15:0] = q.crc;
        default: d.axi.rdata = 32'h00000000;
      endcase
    end

    // Byte engine; its sticky sets come after the clears above so that a set wins.
    unique case (q.st)
      EMCE_H_IDLE: begin
      end
      EMCE_H_RESET: begin
        if (wrsp.done) begin
          d.pres = !wrsp.bit_val;
          d.st = EMCE_H_IDLE;
        end
      end
      EMCE_H_BITS: begin
        if (wrsp.done) begin
          smp = q.rd ? wrsp.bit_val : q.shreg[0];
          // A released one-slot that reads low means another party drove the line.
          if (!q.rd && q.shreg[0] && !wrsp.bit_val) begin
            d.fault = 1'b1;
          end
          d.crc = crc_step(q.crc, smp);
          d.shreg = {smp, q.shreg[7:1]};
          if (q.bitn == 3'h7) begin
            d.st = EMCE_H_IDLE;
            if (q.rd) begin
              d.rxd = {smp, q.shreg[7:1]};
            end
          end else begin
            d.bitn = q.bitn + 3'h1;
            d.wcmd.valid = 1'b1;
            d.wcmd.kind = slot_of(q.rd, q.shreg[1]);
          end
        end
      end
      EMCE_H_WAIT: begin
        // The line stays released so the device keeps its supply while it programs.
        if (q.wcnt == 20'(PROG_WAIT_CYC) - 20'h00001) begin
          d.st = EMCE_H_IDLE;
        end else begin
          d.wcnt = q.wcnt + 20'h00001;
        end
      end
    endcase

    d.wcmd.od = d.od;
    d.low_lvl = 1'b0;
    d.axi.awready = !d.aw_got && !d.axi.bvalid;
    d.axi.wready = !d.w_got && !d.axi.bvalid;
    d.axi.arready = !d.axi.rvalid;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end

  assign axi_rsp_out = q.axi;
  assign line_low_out = q.low_lvl;

  // Helper for the checks below: length of the current low drive.
  logic [15:0] low_cnt_q;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !line_oe_out) begin
      low_cnt_q <= 16'h0000;
    end else if (ce_in && low_cnt_q != 16'hFFFF) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  a_idle_released: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.st == EMCE_H_IDLE || q.st == EMCE_H_WAIT) |-> !line_oe_out)
    else $error("line driven while the engine is idle");

  a_wait_span: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(q.st == EMCE_H_WAIT) |-> (q.st == EMCE_H_WAIT && !line_oe_out)[*8])
    else $error("program wait ended early or drove the line");

  a_reset_low_len: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    ($fell(line_oe_out) && q.st == EMCE_H_RESET) |->
      low_cnt_q == (q.od ? 16'(RSTL_OD_CYC) : 16'(RSTL_STD_CYC)))
    else $error("reset pulse length wrong");

  a_slot_low_max: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.st == EMCE_H_BITS) |->
      low_cnt_q <= (q.od ? 16'(IDLE_LOW_OD_CYC) : 16'(IDLE_LOW_STD_CYC)))
    else $error("slot held the line low too long");

  a_bytes_need_pres: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(q.st == EMCE_H_BITS) |-> q.pres && q.wcmd.valid)
    else $error("byte transfer started without presence");

  a_presence_flag: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.st == EMCE_H_RESET && wrsp.done) |=> (q.st == EMCE_H_IDLE && q.pres == !$past(wrsp.bit_val)))
    else $error("presence flag does not follow the sampled level");

  a_byte_eight: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.st == EMCE_H_BITS && wrsp.done && ce_in) |=>
      ((q.st == EMCE_H_IDLE) == ($past(q.bitn) == 3'h7)))
    else $error("byte not made of eight slots");

  a_open_drain: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    line_oe_out |-> !line_low_out)
    else $error("line driven high");

  a_bvalid_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.axi.bvalid && !axi_req_in.bready && ce_in) |=> q.axi.bvalid)
    else $error("write response dropped before acceptance");

  a_rvalid_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.axi.rvalid && !axi_req_in.rready && ce_in) |=> (q.axi.rvalid && $stable(q.axi.rdata)))
    else $error("read data dropped or changed before acceptance");

  // A command that lands while the engine works is refused, but its overdrive bit still sets the speed of the remaining slots.
  a_busy_refused: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.st != EMCE_H_IDLE && q.aw_got && q.w_got && !q.axi.bvalid && ce_in &&
      q.awaddr == `EMCE_REG_CTRL && q.wstrb[0] && q.wdata[2:0] != 3'h0) |=> q.refused)
    else $error("command taken while busy");

  // Read slots only start the slot; a longer low would hide the device's answer.
  a_read_slot_short: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (q.st == EMCE_H_BITS && q.rd) |->
      low_cnt_q <= (q.od ? 16'(`EMCE_CYC(`EMCE_T_W1L_OD_NS)) :
        16'(`EMCE_CYC(`EMCE_T_W1L_STD_NS))))
    else $error("read slot held the line low too long");

  c_presence: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    q.st == EMCE_H_RESET && wrsp.done && !wrsp.bit_val);
  c_write_byte: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    q.st == EMCE_H_BITS && !q.rd && q.bitn == 3'h7 && wrsp.done);
  c_read_byte: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    q.st == EMCE_H_BITS && q.rd && q.bitn == 3'h7 && wrsp.done);
  c_prog_wait: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    $fell(q.st == EMCE_H_WAIT));
endmodule // emce_host
`default_nettype wire

// ---- bench/emce_dev_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module emce_dev_model #(
  parameter int PROG_NS = 400
) (
  input wire logic line_in,
  input wire logic od_in,
  output var logic pull_out,
  output var logic prog_viol_out
);
  logic [7:0] mem [0:511];
  logic [7:0] pad [0:31];
  logic [7:0] ta_lo, ta_hi, es;
  logic [15:0] crc;
  logic alive, in_prog, wr_data;
  int nbit;
  int unsigned k;

  // Overdrive only when the bench places the device there; timing scales by eight.
  always_comb k = od_in ? 1 : 8;

  task automatic rx(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge line_in);
      #(3000 * k);
      v[i] = line_in;
      nbit++;
      crc = (crc >> 1) ^ ({16{crc[0] ^ v[i]}} & 16'hA001);
    end
  endtask

  // The port only ever pulls low; the pull-up makes the high level.
  task automatic tx(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge line_in);
      if (!v[i]) begin
        pull_out = 1'b1;
        #(4000 * k);
        pull_out = 1'b0;
      end
    end
  endtask

  task automatic load(input int q);
    for (int i = 0; i < 32; i++) pad[i] = mem[{q[8:5], i[4:0]}];
  endtask

  task automatic session();
    logic [7:0] c, a, b, e;
    int p;
    crc = 16'h0000;
    rx(c);
    case (c)
      8'h0F: begin
        rx(ta_lo);
        rx(b);
        ta_hi = b & 8'h01;
        p = ta_lo[4:0];
        es = {3'b000, ta_lo[4:0]};
        wr_data = 1'b1;
        do begin
          nbit = 0;
          rx(b);
          pad[p] = b;
          es[4:0] = p[4:0];
          p++;
        end while (p < 32);
        wr_data = 1'b0;
        e = ~crc[15:8];
        tx(~crc[7:0]);
        tx(e);
      end
      8'hAA: begin
        tx(ta_lo);
        tx(ta_hi);
        tx(es);
        for (p = ta_lo[4:0]; p < 32; p++) tx(pad[p]);
        forever tx(8'hFF);
      end
      8'h55: begin
        rx(a);
        rx(b);
        rx(e);
        if ({a, b, e} === {ta_lo, ta_hi, es} && !es[5]) begin
          es[7] = 1'b1;
          for (p = ta_lo[4:0]; p <= es[4:0]; p++) mem[{ta_hi[0], ta_lo[7:5], p[4:0]}] = pad[p];
          in_prog = 1'b1;
          #(PROG_NS);
          in_prog = 1'b0;
          forever tx(8'hAA);
        end
      end
      8'hF0: begin
        rx(ta_lo);
        rx(b);
        ta_hi = b & 8'h01;
        p = {ta_hi[0], ta_lo};
        load(p);
        forever begin
          tx(p > 511 ? 8'hFF : mem[p]);
          if (p[4:0] == 5'h1F && p < 511) load(p + 1);
          p++;
        end
      end
      default: ;
    endcase
  endtask

  task automatic watch_reset();
    time t;
    forever begin
      @(negedge line_in);
      t = $time;
      @(posedge line_in);
      if ($time - t > 40000 * k) return;
    end
  endtask

  always @(negedge line_in) if (in_prog) prog_viol_out = 1'b1;

  initial begin
    pull_out = 1'b0;
    prog_viol_out = 1'b0;
    alive = 1'b0;
    wr_data = 1'b0;
    nbit = 0;
    es = 8'h20;
    ta_lo = 8'h00;
    ta_hi = 8'h00;
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
    forever begin
      in_prog = 1'b0;
      fork
        begin
          if (alive) session();
          wait (1'b0);
        end
        watch_reset();
      join_any
      disable fork;
      // A write cut inside a data byte leaves the scratchpad marked untrusted.
      if (wr_data && nbit != 0) es[5] = 1'b1;
      wr_data = 1'b0;
      pull_out = 1'b0;
      alive = 1'b1;
      #(1000 * k);
      pull_out = 1'b1;
      #(14000 * k);
      pull_out = 1'b0;
    end
  end
endmodule // emce_dev_model

`default_nettype wire

// ---- bench/emce_host_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "emce_params.svh"

module emce_host_tb_top;
  import emce_pkg::*;
  logic clk_sys_in, reset_in, host_oe, host_low, dev_pull, dev_od, prog_viol, line_lvl;
  emce_axi_req_s req;
  emce_axi_rsp_s rsp;
  int err_total, compares, cyc;

  assign line_lvl = !(host_oe | dev_pull);

  emce_host #(.PROG_WAIT_CYC(40)) dut (
    .clk_sys_in(clk_sys_in), .ce_in(1'b1), .reset_in(reset_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .line_in(line_lvl), .line_low_out(host_low), .line_oe_out(host_oe));
  emce_dev_model #(.PROG_NS(400)) dev (
    .line_in(line_lvl), .od_in(dev_od), .pull_out(dev_pull), .prog_viol_out(prog_viol));

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_in);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Every line operation runs at overdrive speed to keep the run short.
  task automatic op(input logic [2:0] o);
    logic [31:0] s;
    logic [1:0] r;
    wr(`EMCE_REG_CTRL, {28'h0, 1'b1, o});
    s = 32'h1;
    while (s[0] !== 1'b0) rd(`EMCE_REG_STAT, s, r);
  endtask

  task automatic send(input logic [7:0] b);
    wr(`EMCE_REG_TXD, {24'h0, b});
    op(3'h2);
  endtask

  task automatic recv(input string n, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    op(3'h3);
    rd(`EMCE_REG_RXD, d, r);
    chk(n, {24'h0, e}, d);
  endtask

  task automatic stat_bit(input string n, input int i, input logic e);
    logic [31:0] s;
    logic [1:0] r;
    rd(`EMCE_REG_STAT, s, r);
    chk(n, {31'h0, e}, {31'h0, s[i]});
  endtask

  task automatic rst();
    op(3'h1);
    stat_bit("presence", 1, 1'b1);
    chk("line drive level", 32'h0, {31'h0, host_low});
  endtask

  task automatic t_refuse();
    logic [31:0] s;
    logic [1:0] r;
    rd(`EMCE_REG_STAT, s, r);
    chk("status after reset", 32'h0, s);
    rd(8'h14, s, r);
    chk("unmapped response", 32'h2, {30'h0, r});
    dev_od = 1'b1;
    wr(`EMCE_REG_CTRL, 32'h8);
    stat_bit("overdrive set", 2, 1'b1);
    op(3'h2);
    stat_bit("byte without presence", 3, 1'b1);
    wr(`EMCE_REG_STAT, 32'h8);
    stat_bit("refused cleared", 3, 1'b0);
    op(3'h5);
    stat_bit("bad op refused", 3, 1'b1);
    wr(`EMCE_REG_STAT, 32'h8);
  endtask

  task automatic t_write();
    logic [31:0] s;
    logic [1:0] r;
    rst();
    wr(`EMCE_REG_CRC, 32'h0);
    send(8'h0F);
    send(8'h1F);
    send(8'hFE);
    send(8'hC3);
    op(3'h3);
    op(3'h3);
    stat_bit("crc residue ok", 5, 1'b1);
    rd(`EMCE_REG_CRC, s, r);
    chk("crc residue", 32'hB001, s);
  endtask

  task automatic t_readsp();
    rst();
    send(8'hAA);
    recv("target low", 8'h1F);
    recv("target high masked", 8'h00);
    recv("end status", 8'h1F);
    recv("pad data", 8'hC3);
    recv("past end", 8'hFF);
  endtask

  task automatic t_copy();
    rst();
    send(8'h55);
    send(8'h1F);
    send(8'h00);
    send(8'h1F);
    op(3'h4);
    recv("done pattern", 8'hAA);
    chk("line held during program", 32'h0, {31'h0, prog_viol});
  endtask

  task automatic t_readmem();
    rst();
    send(8'hF0);
    send(8'h1F);
    send(8'hFE);
    recv("copied byte", 8'hC3);
    rst();
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 170000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  initial begin
    req = '0;
    reset_in = 1'b1;
    dev_od = 1'b0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    repeat (4) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_refuse();
    t_write();
    t_readsp();
    t_copy();
    t_readmem();
    finish_test();
  end
endmodule // emce_host_tb_top

`default_nettype wire
